/* File: pkg/shc_if.sv */
// Purpose: Control-word link between host controller and device bank.
// Assumes: One clock; request is one cycle, answer one cycle later.
// Notes:   Each word travels with complement and CRC8 check fields.
`timescale 1ns/1ps
`default_nettype none
interface shc_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] wdata_n;
  logic [7:0] wcrc;
  logic ack;
  logic [31:0] rdata;
  logic [31:0] rdata_n;
  logic [7:0] rcrc;
  logic err;
  modport dev (input req, wr, addr, wdata, wdata_n, wcrc,
               output ack, rdata, rdata_n, rcrc, err);
  modport host (output req, wr, addr, wdata, wdata_n, wcrc,
                input ack, rdata, rdata_n, rcrc, err);
endinterface
`default_nettype wire

/* File: pkg/shc_map.svh */
// Purpose: Offsets, field positions, reset values and codes for the
//          host-protocol configuration bank.
// Assumes: Register index is the printed offset; one 32-bit word each.
// Notes:   Definitions only.
`ifndef SHC_MAP_SVH
`define SHC_MAP_SVH
`define SHC_ADDR_W 8
`define SHC_OFF_CONFIG0 8'h04
`define SHC_OFF_CFG_TWO 8'h06
`define SHC_OFF_CAPAB 8'h02
`define SHC_OFF_STATUS 8'h10
`define SHC_OFF_HCTRL 8'h00
`define SHC_OFF_HSTAT 8'h01
`define SHC_OFF_HDATA 8'h02
`define SHC_REMOTE_BIT 7
`define SHC_CFG0_RST 32'h0000_0006
`define SHC_CFG2_RST 32'h0000_0800
`define SHC_CFG0_WMASK 32'h0000_01a7
`define SHC_CFG2_WMASK 32'h0001_f9ff
`define SHC_BIT_FSE 8
`define SHC_BIT_FSS 7
`define SHC_BIT_PROT 6
`define SHC_BIT_RETRY 5
`define SHC_SEL_LSB 0
`define SHC_SEL_MSB 2
`define SHC_SEL_MIN 3'h3
`define SHC_SEL_MAX 3'h6
`define SHC_SEL_16 3'h4
`define SHC_SEL_32 3'h5
`define SHC_SEL_64 3'h6
`define SHC_SEL_FLOOR 3'h3
`define SHC_STRAP_SETTLE 2'h2
`define SHC_CRC8_POLY 8'h07
`define SHC_CRC8_INIT 8'h00
`define SHC_ST_STAMP64 0
`define SHC_ST_STAMPON 1
`define SHC_ST_RETRY 2
`define SHC_ST_PERR 3
`define SHC_HS_ERR 0
`define SHC_HS_REFUSED 1
`endif

/* File: pkg/shc_pkg.sv */
// Purpose: Types shared by both ends of the configuration link.
// Assumes: Constants live in shc_map.svh.
// Notes:   Control-word checks are carried as complement and CRC8.
`default_nettype none
`include "shc_map.svh"
package shc_pkg;
  typedef enum logic [1:0] {SHC_MODE_CHUNK, SHC_MODE_GENERIC} shc_mode_t;
  typedef enum logic [1:0] {SHC_IDLE, SHC_REQ, SHC_WAIT} shc_hst_t;
  // Byte-serial CRC8 step, used by both ends
  function automatic logic [7:0] shc_crc8_byte(input logic [7:0] c,
                                              input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      x = x[7] ? ((x << 1) ^ `SHC_CRC8_POLY) : (x << 1);
    end
    return x;
  endfunction
  function automatic logic [7:0] shc_crc8_word(input logic [31:0] w);
    logic [7:0] c;
    c = `SHC_CRC8_INIT;
    for (int i = 3; i >= 0; i--)
    begin
      c = shc_crc8_byte(c, w[i*8 +: 8]);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

/* File: rtl/shc_dev.sv */
// Purpose: Device end: configuration register bank of the host port.
// Assumes: Host keeps one outstanding request; protect strap is static.
// Notes:   Unmapped reads return zero; bad-check writes are dropped.
// What this block does
// - Format bit picks 32 or 64-bit stamps
// - Stamps only when enabled; both reset zero
// - Chunk mode: words carry bitwise complement
// - Generic mode: CRC8 appended both directions
// - Protect bit read-only, strapped at power-up
// - Retry disabled: ignore header sequence bit
// - Retry enabled: unchanged sequence bit means rewrite
// - Payload is two to N, resets 64
// - Selector 100/101/110 gives 16/32/64 bytes
// - Host sets selector before any traffic
// - Host keeps selector stable during frames
// - Selector frozen after sync until reset
// - Host never goes below reported minimum
// - Configuration two at 0x06, resets 0x800
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "shc_map.svh"
module shc_dev
  import shc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  shc_if.dev link,
  input wire logic protect_strap_in,
  input wire logic generic_mode_in,
  input wire logic chunk_valid_in,
  input wire logic chunk_sequence_bit_in,
  output logic stamp_enable_out,
  output logic stamp64_out,
  output logic chunk_rewrite_out,
  output logic chunk_accept_out,
  output logic [6:0] chunk_bytes_out,
  output logic [31:0] config0_out,
  output logic [31:0] configuration_two_out
);
  typedef struct packed {
    logic [31:0] cfg0;
    logic [31:0] cfg2;
    logic protect;
    logic strap_s1;
    logic strap_s2;
    logic strap_done;
    logic [1:0] strap_cnt;
    logic last_seq;
    logic seq_seen;
    logic rewrite;
    logic accept;
    logic ack;
    logic err;
    logic perr;
    logic [31:0] rdata;
  } shc_dev_t;

  shc_dev_t st_r;
  shc_dev_t st_nxt;
  logic chk_ok;
  logic [31:0] rd_word;
  logic [31:0] stat_word;

  // Check field of an incoming word depends on the protocol mode
  always_comb
  begin
    chk_ok = 1'b1;
    if (st_r.protect)
    begin
      if (generic_mode_in)
        chk_ok = (shc_crc8_word(link.wdata) == link.wcrc);
      else
        chk_ok = (link.wdata_n == ~link.wdata);
    end
  end

  // Status word exposes decoded behaviour of the bank
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`SHC_ST_STAMP64] = stamp64_out;
    stat_word[`SHC_ST_STAMPON] = stamp_enable_out;
    stat_word[`SHC_ST_RETRY] = st_r.cfg0[`SHC_BIT_RETRY];
    stat_word[`SHC_ST_PERR] = st_r.perr;
  end

  // Read decode; reserved and unmapped bits read zero
  always_comb
  begin
    case (link.addr)
      `SHC_OFF_CONFIG0:
      begin
        rd_word = st_r.cfg0 & `SHC_CFG0_WMASK;
        rd_word[`SHC_BIT_PROT] = st_r.protect;
      end
      `SHC_OFF_CFG_TWO: rd_word = st_r.cfg2;
      `SHC_OFF_CAPAB: rd_word = {29'h0, `SHC_SEL_FLOOR};
      `SHC_OFF_STATUS: rd_word = stat_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next-state logic of the whole bank
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.rewrite = 1'b0;
    st_nxt.accept = 1'b0;
    // Strap passes two flops; protect is latched only once the pair has
    // filled, since their reset zeros would otherwise be captured
    st_nxt.strap_s1 = protect_strap_in;
    st_nxt.strap_s2 = st_r.strap_s1;
    if (st_r.strap_cnt != `SHC_STRAP_SETTLE)
      st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
    else if (!st_r.strap_done)
    begin
      st_nxt.protect = st_r.strap_s2;
      st_nxt.strap_done = 1'b1;
    end
    if (link.req)
    begin
      st_nxt.ack = 1'b1;
      if (!chk_ok)
      begin
        st_nxt.err = 1'b1; // Corrupt word: flag it, store nothing
        st_nxt.perr = 1'b1;
        st_nxt.rdata = 32'h0000_0000;
      end
      else if (link.wr)
      begin
        // Masked writes keep protect and reserved bits fixed
        if (link.addr == `SHC_OFF_CONFIG0)
          st_nxt.cfg0 = link.wdata & `SHC_CFG0_WMASK;
        else if (link.addr == `SHC_OFF_CFG_TWO)
          st_nxt.cfg2 = link.wdata & `SHC_CFG2_WMASK;
        else if (link.addr == `SHC_OFF_STATUS)
          st_nxt.perr = st_r.perr & ~link.wdata[`SHC_ST_PERR];
        st_nxt.rdata = 32'h0000_0000;
      end
      else
        st_nxt.rdata = rd_word;
    end
    // Sequence monitor for transmit chunk headers
    if (chunk_valid_in)
    begin
      st_nxt.accept = 1'b1;
      if (st_r.cfg0[`SHC_BIT_RETRY])
      begin
        st_nxt.rewrite = st_r.seq_seen &&
          (chunk_sequence_bit_in == st_r.last_seq);
        st_nxt.last_seq = chunk_sequence_bit_in;
        st_nxt.seq_seen = 1'b1;
      end
    end
  end

  // State register; reset values are constants only
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
      st_r.cfg0 <= `SHC_CFG0_RST;
      st_r.cfg2 <= `SHC_CFG2_RST;
    end
    else if (ce_in)
      st_r <= st_nxt;
  end

  // Payload size is two to the selector; out-of-range codes clamp
  // to the largest size, so a stray code never shortens a chunk
  // below what the receive side already expects
  always_comb
  begin
    case (st_r.cfg0[`SHC_SEL_MSB:`SHC_SEL_LSB])
      `SHC_SEL_MIN: chunk_bytes_out = 7'h08;
      `SHC_SEL_16: chunk_bytes_out = 7'h10;
      `SHC_SEL_32: chunk_bytes_out = 7'h20;
      `SHC_SEL_64: chunk_bytes_out = 7'h40;
      default: chunk_bytes_out = 7'h40;
    endcase
  end

  // Format takes effect only when stamps are on
  assign stamp_enable_out = st_r.cfg0[`SHC_BIT_FSE];
  assign stamp64_out = st_r.cfg0[`SHC_BIT_FSE] &
                       st_r.cfg0[`SHC_BIT_FSS];
  assign chunk_rewrite_out = st_r.rewrite;
  assign chunk_accept_out = st_r.accept;
  assign configuration_two_out = st_r.cfg2;

  // Read view of config0 with the strapped protect bit in place;
  // kept as a process so it follows every change of the state word
  always_comb
  begin
    config0_out = st_r.cfg0 & `SHC_CFG0_WMASK;
    config0_out[`SHC_BIT_PROT] = st_r.protect;
  end

  // Read data leaves with complement and CRC8 for the host to check
  assign link.ack = st_r.ack;
  assign link.err = st_r.err;
  assign link.rdata = st_r.rdata;
  assign link.rdata_n = ~st_r.rdata;
  assign link.rcrc = shc_crc8_word(st_r.rdata);
endmodule
`default_nettype wire

/* File: rtl/shc_host.sv */
// Purpose: Host end: issues control words and checks read answers.
// Assumes: Software drives the plain command port below.
// Notes:   Selector writes are blocked while frames are active or sync.
`timescale 1ns/1ps
`default_nettype none
`include "shc_map.svh"
module shc_host
  import shc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  shc_if.host link,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic protect_in,
  input wire logic generic_mode_in,
  input wire logic frame_active_in,
  input wire logic sync_set_in,
  output logic busy_out
);
  typedef struct packed {
    shc_hst_t state;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] last_rd;
    logic [3:0] status;
    logic synced;
    logic [2:0] min_sel;
    logic [31:0] rdata;
  } shc_host_t;

  shc_host_t st_r;
  shc_host_t st_nxt;
  logic rd_ok;
  logic [2:0] sel;
  logic sel_bad;

  // Answer check matches the active protocol mode
  always_comb
  begin
    if (!protect_in)
      rd_ok = 1'b1;
    else if (generic_mode_in)
      rd_ok = (shc_crc8_word(link.rdata) == link.rcrc);
    else
      rd_ok = (link.rdata_n == ~link.rdata);
  end

  // Selector writes refused when illegal for the current phase
  assign sel = wdata_in[`SHC_SEL_MSB:`SHC_SEL_LSB];
  assign sel_bad = (addr_in == `SHC_OFF_CONFIG0) &&
    (frame_active_in ||
     st_r.synced ||
     sel < st_r.min_sel || sel > `SHC_SEL_MAX);

  always_comb
  begin
    st_nxt = st_r;
    if (sync_set_in)
      st_nxt.synced = 1'b1;
    if (rd_in)
    begin
      st_nxt.rdata = 32'h0000_0000;
      case (addr_in)
        `SHC_OFF_HSTAT: st_nxt.rdata = {28'h0, st_r.status};
        `SHC_OFF_HDATA: st_nxt.rdata = st_r.last_rd;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    case (st_r.state)
      SHC_IDLE:
      begin
        // Plain writes go out as remote writes; the high address bit
        // marks a remote read
        if (wr_in && !addr_in[`SHC_REMOTE_BIT])
        begin
          st_nxt.wr = 1'b1;
          st_nxt.addr = addr_in;
          st_nxt.wdata = wdata_in;
          st_nxt.state = sel_bad ? SHC_IDLE : SHC_REQ;
          st_nxt.status[`SHC_HS_REFUSED] = sel_bad;
        end
        else if (rd_in && addr_in[`SHC_REMOTE_BIT])
        begin
          st_nxt.wr = 1'b0;
          st_nxt.addr = addr_in;
          st_nxt.addr[`SHC_REMOTE_BIT] = 1'b0;
          st_nxt.wdata = 32'h0000_0000;
          st_nxt.state = SHC_REQ;
        end
        else
          st_nxt.state = SHC_IDLE;
      end
      SHC_REQ: st_nxt.state = SHC_WAIT;
      SHC_WAIT:
      begin
        if (link.ack)
        begin
          st_nxt.state = SHC_IDLE;
          st_nxt.status[`SHC_HS_ERR] = link.err | ~rd_ok;
          if (!st_r.wr)
          begin
            st_nxt.last_rd = link.rdata;
            if (st_r.addr == `SHC_OFF_CAPAB)
              st_nxt.min_sel = link.rdata[`SHC_SEL_MSB:`SHC_SEL_LSB];
          end
        end
      end
      default: st_nxt.state = SHC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
      st_r.state <= SHC_IDLE;
      st_r.min_sel <= `SHC_SEL_MIN;
    end
    else if (ce_in)
      st_r <= st_nxt;
  end

  // Outgoing word carries both check fields; device uses the one in force
  assign link.req = (st_r.state == SHC_REQ);
  assign link.wr = st_r.wr;
  assign link.addr = st_r.addr;
  assign link.wdata = st_r.wdata;
  assign link.wdata_n = ~st_r.wdata;
  assign link.wcrc = shc_crc8_word(st_r.wdata);
  assign rdata_out = st_r.rdata;
  assign busy_out = (st_r.state != SHC_IDLE);
endmodule
`default_nettype wire

/* File: tb/shc_link_chk.sv */
// Purpose: Assertions on the host-device control-word link.
// Assumes: Clock enable held high on both ends.
// Notes: CRC8 model of its own, bitwise, MSB first.
`timescale 1ns/1ps
`default_nettype none
module shc_link_chk (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] wdata_n,
  input wire logic [7:0] wcrc,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic [31:0] rdata_n,
  input wire logic [7:0] rcrc,
  input wire logic err
);
  // Poly 07, init 00; bit order matches byte order MSB first
  function automatic logic [7:0] crc_w(input logic [31:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // Answer timing and spacing
  property p_ack;
    req |=> ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_cause;
    ack |-> $past(req) && !err;
  endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  property p_space;
    req |=> !req [*2];
  endproperty
  a_space: assert property (p_space) else $error("requests too close");
  // Check fields on both directions
  property p_wcmp;
    req && wr |-> wdata_n == ~wdata;
  endproperty
  a_wcmp: assert property (p_wcmp) else $error("bad complement");
  property p_wcrc;
    req && wr |-> wcrc == crc_w(wdata);
  endproperty
  a_wcrc: assert property (p_wcrc) else $error("bad crc");
  property p_rcmp;
    req && !wr |=> rdata_n == ~rdata;
  endproperty
  a_rcmp: assert property (p_rcmp) else $error("bad complement");
  property p_rcrc;
    req && !wr |=> rcrc == crc_w(rdata);
  endproperty
  a_rcrc: assert property (p_rcrc) else $error("bad crc");
  property p_resv;
    req && !wr && addr == 8'h06 |=> rdata[31:17] == 15'h0 && !rdata[10:9];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  c_wr: cover property (req && wr);
  c_rd: cover property (req && !wr ##1 ack);
  c_c2: cover property (req && wr && addr == 8'h06);
endmodule
`default_nettype wire

/* File: tb/spi_host_protocol_config_tb.sv */
// Purpose: Directed regression of the configuration link.
// Assumes: Clock enable high; strap high, so protect reads one.
// Notes: A second device end faces a faulty driver.
`timescale 1ns/1ps
`default_nettype none
module spi_host_protocol_config_tb;
  logic clk_sys_in, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic strap = 1'b1, gmode = 1'b0, gen2 = 1'b0, fa = 1'b0, sy = 1'b0;
  logic cv = 1'b0, cs = 1'b0, busy, se, s64, rw, acc;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out, cfg2_b;
  logic [6:0] cb;
  int bad_count = 0, samples_checked = 0;
  shc_if link_if();
  shc_if bad_if();
  // Both ends face each other; a spare device meets the faulty driver
  shc_dev shc_dev_inst (.clk_sys_in, .rst_in, .ce_in(1'b1), .link(link_if),
    .protect_strap_in(strap), .generic_mode_in(gmode), .chunk_valid_in(cv),
    .chunk_sequence_bit_in(cs), .stamp_enable_out(se), .stamp64_out(s64),
    .chunk_rewrite_out(rw), .chunk_accept_out(acc), .chunk_bytes_out(cb),
    .config0_out(), .configuration_two_out());
  shc_dev shc_dev_bad_inst (.clk_sys_in, .rst_in, .ce_in(1'b1),
    .link(bad_if), .protect_strap_in(strap), .generic_mode_in(gen2),
    .chunk_valid_in(1'b0), .chunk_sequence_bit_in(1'b0),
    .stamp_enable_out(), .stamp64_out(), .chunk_rewrite_out(),
    .chunk_accept_out(), .chunk_bytes_out(), .config0_out(),
    .configuration_two_out(cfg2_b));
  shc_host shc_host_inst (.clk_sys_in, .rst_in, .ce_in(1'b1), .link(link_if),
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .protect_in(strap),
    .generic_mode_in(gmode), .frame_active_in(fa), .sync_set_in(sy),
    .busy_out(busy));
  shc_link_chk shc_link_chk_inst (.clk_sys_in, .rst_in, .req(link_if.req),
    .wr(link_if.wr), .addr(link_if.addr), .wdata(link_if.wdata),
    .wdata_n(link_if.wdata_n), .wcrc(link_if.wcrc), .ack(link_if.ack),
    .rdata(link_if.rdata), .rdata_n(link_if.rdata_n),
    .rcrc(link_if.rcrc), .err(link_if.err));
  // 100 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One strobe cycle on the command port, then a bounded wait for idle
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1;
    for (n = 0; n < 20 && busy !== 1'b0; n++)
    begin
      @(posedge clk_sys_in);
      #1;
    end
    if (n == 20)
    begin
      chk("busy", 32'h0, 32'h1);
      end_sim();
    end
  endtask
  // Remote read, then the local data window shows it one cycle later
  task automatic lrd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    chk("read", e, rdata_out);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    op(a | 8'h80, 32'h0, 1'b0);
    lrd(8'h02, e);
  endtask
  task automatic chunk(input logic s, input logic e);
    @(posedge clk_sys_in);
    cv <= 1'b1;
    cs <= s;
    @(posedge clk_sys_in);
    cv <= 1'b0;
    #1;
    chk("chunk", {31'h1, e}, {30'h0, acc, rw});
  endtask
  // Faulty driver: one write of zero to config two with chosen checks
  task automatic bad_wr(input logic [31:0] n, input logic [7:0] c, logic e);
    @(posedge clk_sys_in);
    bad_if.req <= 1'b1;
    bad_if.wdata_n <= n;
    bad_if.wcrc <= c;
    @(posedge clk_sys_in);
    bad_if.req <= 1'b0;
    #1;
    chk("fault", {31'h1, e}, {30'h0, bad_if.ack, bad_if.err});
  endtask
  task automatic do_reset();
    @(posedge clk_sys_in) rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask
  // Main sequence
  initial
  begin
    bad_if.req = 1'b0;
    bad_if.wr = 1'b1;
    bad_if.addr = 8'h06;
    bad_if.wdata = 32'h0;
    do_reset();
    rd(8'h04, 32'h46);
    rd(8'h06, 32'h800);
    rd(8'h02, 32'h3);
    chk("bytes", 32'h40, {25'h0, cb});
    chk("stamp", 32'h0, {30'h0, se, s64});
    $display("reset test end");
    @(posedge clk_sys_in) gmode <= 1'b1;
    for (int s = 3; s <= 6; s++)
    begin
      op(8'h04, 32'h80 | s, 1'b1);
      chk("bytes", 32'h1 << s, {25'h0, cb});
      chk("stamp", 32'h0, {30'h0, se, s64});
      rd(8'h04, 32'hc0 | s);
    end
    $display("selector test end");
    @(posedge clk_sys_in) gmode <= 1'b0;
    chunk(1'b0, 1'b0);
    chunk(1'b0, 1'b0);
    op(8'h04, 32'hffffffbc, 1'b1);
    rd(8'h04, 32'h1e4);
    chk("stamp", 32'h3, {30'h0, se, s64});
    chunk(1'b1, 1'b0);
    chunk(1'b1, 1'b1);
    chunk(1'b0, 1'b0);
    op(8'h06, 32'hffffffff, 1'b1);
    rd(8'h06, 32'h1f9ff);
    rd(8'h30, 32'h0);
    $display("retry test end");
    @(posedge clk_sys_in) fa <= 1'b1;
    op(8'h04, 32'h3, 1'b1);
    lrd(8'h01, 32'h2);
    @(posedge clk_sys_in) fa <= 1'b0;
    op(8'h04, 32'h2, 1'b1);
    op(8'h04, 32'h7, 1'b1);
    @(posedge clk_sys_in) sy <= 1'b1;
    @(posedge clk_sys_in) sy <= 1'b0;
    op(8'h04, 32'h5, 1'b1);
    rd(8'h04, 32'h1e4);
    do_reset();
    op(8'h04, 32'h5, 1'b1);
    rd(8'h04, 32'h45);
    $display("refusal test end");
    bad_wr(32'h0, 8'h00, 1'b1);
    @(posedge clk_sys_in) gen2 <= 1'b1;
    bad_wr(32'hffffffff, 8'h5a, 1'b1);
    chk("store", 32'h800, cfg2_b);
    bad_wr(32'hffffffff, 8'h00, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    chk("store", 32'h0, cfg2_b);
    $display("fault test end");
    end_sim();
  end
endmodule
`default_nettype wire
